// >>> logic/standby_wake_wait_and_clock_select.sv
// Module: wake wait selector, watch exit clock selector and their Wishbone slave
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/100ps

module standby_wake_wait_and_clock_select
    import wake_pkg::*;
#(
    parameter int          CNT_W = wake_pkg::CNT_W_DEF,
    parameter int unsigned WAIT0 = wake_pkg::WAIT_CODE0,
    parameter int unsigned WAIT1 = wake_pkg::WAIT_CODE1,
    parameter int unsigned WAIT2 = wake_pkg::WAIT_CODE2,
    parameter int unsigned WAIT3 = wake_pkg::WAIT_CODE3,
    parameter int unsigned WAIT4 = wake_pkg::WAIT_CODE4,
    parameter int unsigned WAIT5 = wake_pkg::WAIT_CODE5,
    parameter int unsigned WAIT6 = wake_pkg::WAIT_CODE6,
    parameter int unsigned WAIT7 = wake_pkg::WAIT_CODE7
)
(
    input  wire logic                          i_clk,
    input  wire logic                          i_resetn,
    // Wishbone classic slave
    input  wire logic                          i_wb_cyc,
    input  wire logic                          i_wb_stb,
    input  wire logic                          i_wb_we,
    input  wire logic [wake_pkg::ADR_W-1:0]    i_wb_adr,
    input  wire logic [3:0]                    i_wb_sel,
    input  wire logic [wake_pkg::BUS_DW-1:0]   i_wb_dat,
    output logic      [wake_pkg::BUS_DW-1:0]   o_wb_dat,
    output logic                               o_wb_ack,
    // Power-mode events
    input  wire logic                          i_wake_event,
    input  wire logic                          i_watch_exit,
    // Results
    output logic                               o_hold,
    output logic                               o_cpu_clk_sub
);
    import wake_pkg::*;

    wake_wait_if #(.CNT_W(CNT_W)) wait_bus ();

    logic [WAIT_SEL_W-1:0] wake_wait_sel;
    logic [WAIT_SEL_W-1:0] next_wake_wait_sel;
    logic                  watch_exit_clock_sel;
    logic                  next_watch_exit_clock_sel;
    logic                  cpu_clk;
    logic                  next_cpu_clk;
    logic                  ack;
    logic                  next_ack;
    logic [BUS_DW-1:0]     rd_data;
    logic [BUS_DW-1:0]     next_rd_data;
    logic                  req;
    logic                  wr_commit;

    // ----------------------------------------------------------------
    // Wait table lookup
    // ----------------------------------------------------------------
    // Each code maps to a state count; used by the load and by a check
    function automatic logic [CNT_W-1:0] wait_states(input logic [WAIT_SEL_W-1:0] code);
        unique case (code)
            3'h0:    wait_states = CNT_W'(WAIT0);
            3'h1:    wait_states = CNT_W'(WAIT1);
            3'h2:    wait_states = CNT_W'(WAIT2);
            3'h3:    wait_states = CNT_W'(WAIT3);
            3'h4:    wait_states = CNT_W'(WAIT4);
            3'h5:    wait_states = CNT_W'(WAIT5);
            3'h6:    wait_states = CNT_W'(WAIT6);
            3'h7:    wait_states = CNT_W'(WAIT7);
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    // Ack one cycle after the request; the write lands on the ack edge
    assign req       = i_wb_cyc & i_wb_stb;
    assign wr_commit = req & i_wb_we & ack & i_wb_sel[0];

    always_comb
    begin
        next_ack     = req & ~ack;
        next_rd_data = rd_data;
        if (req & ~ack)
        begin
            unique case (i_wb_adr)
                ADR_CTRL:
                begin
                    next_rd_data                            = RD_ZERO;
                    next_rd_data[WAIT_SEL_MSB:WAIT_SEL_LSB] = wake_wait_sel;
                    next_rd_data[CLK_SEL_BIT]               = watch_exit_clock_sel;
                    next_rd_data[RSVD_BIT]                  = RSVD_VAL;
                end
                ADR_STATUS:
                begin
                    next_rd_data              = RD_ZERO;
                    next_rd_data[ST_HOLD_BIT] = wait_bus.busy;
                    next_rd_data[ST_CLK_BIT]  = cpu_clk;
                end
                default: next_rd_data = RD_ZERO;   // Unmapped: acked, reads zero
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ack     <= 1'b0;
            rd_data <= RD_ZERO;
        end
        else
        begin
            ack     <= next_ack;
            rd_data <= next_rd_data;
        end
    end

    assign o_wb_ack = ack;
    assign o_wb_dat = rd_data;

    // ----------------------------------------------------------------
    // Selector registers
    // ----------------------------------------------------------------
    // Only byte lane 0 holds fields; other lanes are ignored
    always_comb
    begin
        next_wake_wait_sel        = wake_wait_sel;
        next_watch_exit_clock_sel = watch_exit_clock_sel;
        if (wr_commit && i_wb_adr == ADR_CTRL)
        begin
            next_wake_wait_sel        = i_wb_dat[WAIT_SEL_MSB:WAIT_SEL_LSB];
            next_watch_exit_clock_sel = i_wb_dat[CLK_SEL_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            wake_wait_sel        <= WAIT_SEL_RST;
            watch_exit_clock_sel <= CLK_SEL_RST;
        end
        else
        begin
            wake_wait_sel        <= next_wake_wait_sel;
            watch_exit_clock_sel <= next_watch_exit_clock_sel;
        end
    end

    // ----------------------------------------------------------------
    // Wake wait
    // ----------------------------------------------------------------
    // No check against the oscillator: a short code simply releases early
    assign wait_bus.load       = i_wake_event & ~wait_bus.busy;
    assign wait_bus.load_count = wait_states(wake_wait_sel);

    wake_wait_counter #(.CNT_W(CNT_W)) u_counter (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .wait_port (wait_bus.cnt)
    );

    assign o_hold = wait_bus.busy;

    // ----------------------------------------------------------------
    // CPU clock after watch exit
    // ----------------------------------------------------------------
    // Sampled only at watch exit so later writes do not glitch the CPU clock
    always_comb
    begin
        next_cpu_clk = cpu_clk;
        if (i_watch_exit)
            next_cpu_clk = watch_exit_clock_sel ? CLK_SUB : CLK_MAIN;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            cpu_clk <= CLK_MAIN;
        else
            cpu_clk <= next_cpu_clk;
    end

    assign o_cpu_clk_sub = cpu_clk;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence ctrl_write_s;
        wr_commit && i_wb_adr == ADR_CTRL;
    endsequence

    wait_field_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ctrl_write_s |=> wake_wait_sel == $past(i_wb_dat[WAIT_SEL_MSB:WAIT_SEL_LSB]))
        else $error("wait selector did not take written value");

    clk_field_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ctrl_write_s |=> watch_exit_clock_sel == $past(i_wb_dat[CLK_SEL_BIT]))
        else $error("clock selector did not take written value");

    ctrl_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (req && !ack && !i_wb_we && i_wb_adr == ADR_CTRL) |=>
            o_wb_ack && o_wb_dat[WAIT_SEL_MSB:WAIT_SEL_LSB] == $past(wake_wait_sel))
        else $error("control read returned wrong selector");

    wake_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_wake_event && !o_hold) |=> o_hold [*2])
        else $error("wake event did not hold the CPU");

    zero_code_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wait_bus.load && wake_wait_sel == WAIT_SEL_RST) |-> wait_bus.load_count == WAIT0)
        else $error("code zero loaded wrong wait length");

    table_len_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_wake_event && !o_hold) |->
            wait_bus.load && wait_bus.load_count == wait_states(wake_wait_sel))
        else $error("wake did not load the programmed wait");

    main_clk_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_watch_exit && watch_exit_clock_sel == CLK_MAIN) |=> o_cpu_clk_sub == CLK_MAIN)
        else $error("watch exit did not select main clock");

    sub_clk_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_watch_exit && watch_exit_clock_sel == CLK_SUB) |=> o_cpu_clk_sub == CLK_SUB)
        else $error("watch exit did not select subclock");

    clk_steady_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_watch_exit |=> $stable(o_cpu_clk_sub))
        else $error("CPU clock changed without watch exit");

    ack_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");

endmodule

// >>> logic/wake_pkg.sv
// Package: register map, field layout and wake wait defaults for the wake control block
package wake_pkg;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    localparam int          BUS_DW        = 32;
    localparam int          ADR_W         = 4;
    localparam logic [3:0]  ADR_CTRL      = 4'h0;  // Wait and clock selectors
    localparam logic [3:0]  ADR_STATUS    = 4'h4;  // Live block state
    localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int          WAIT_SEL_LSB  = 4;
    localparam int          WAIT_SEL_MSB  = 6;
    localparam int          WAIT_SEL_W    = 3;
    localparam int          CLK_SEL_BIT   = 3;
    localparam int          RSVD_BIT      = 2;
    localparam logic        RSVD_VAL      = 1'b1;  // Reserved bit reads as one
    localparam logic [2:0]  WAIT_SEL_RST  = 3'h0;
    localparam logic        CLK_SEL_RST   = 1'b0;
    localparam logic        CLK_MAIN      = 1'b0;  // Main system clock
    localparam logic        CLK_SUB       = 1'b1;  // Low-frequency subclock

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int          ST_HOLD_BIT   = 0;
    localparam int          ST_CLK_BIT    = 1;

    // ----------------------------------------------------------------
    // Wake wait lengths in states, one state per clock
    // ----------------------------------------------------------------
    localparam int          CNT_W_DEF     = 17;
    localparam int unsigned WAIT_CODE0    = 8192;
    localparam int unsigned WAIT_CODE1    = 16384;
    localparam int unsigned WAIT_CODE2    = 1024;
    localparam int unsigned WAIT_CODE3    = 2048;
    localparam int unsigned WAIT_CODE4    = 4096;
    localparam int unsigned WAIT_CODE5    = 2;     // Shortest, external clock
    localparam int unsigned WAIT_CODE6    = 256;
    localparam int unsigned WAIT_CODE7    = 512;

    // Counter states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } cnt_state_t;

endpackage

// >>> logic/wake_wait_counter.sv
// Module: down counter that holds the CPU for a loaded number of states
`timescale 1ns/100ps
module wake_wait_counter
    import wake_pkg::*;
#(
    parameter int CNT_W = wake_pkg::CNT_W_DEF
)
(
    input  wire logic  i_clk,
    input  wire logic  i_resetn,
    wake_wait_if.cnt   wait_port
);
    import wake_pkg::*;

    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

    cnt_state_t       state;
    cnt_state_t       next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    // ----------------------------------------------------------------
    // Counter control
    // ----------------------------------------------------------------
    // A load while busy is ignored so a second wake cannot stretch the hold
    always_comb
    begin
        next_state = state;
        next_count = count;
        unique case (state)
            ST_IDLE:
            begin
                if (wait_port.load)
                begin
                    next_state = ST_WAIT;
                    next_count = wait_port.load_count - CNT_ONE;
                end
            end
            ST_WAIT:
            begin
                if (count == CNT_ZERO)
                    next_state = ST_IDLE;
                else
                    next_count = count - CNT_ONE;
            end
        endcase
    end

    // Registers only
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state <= ST_IDLE;
            count <= CNT_ZERO;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign wait_port.busy = (state == ST_WAIT);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Helper: measured hold length against the loaded length
    logic [CNT_W-1:0] held;
    logic [CNT_W-1:0] want;
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            held <= CNT_ZERO;
            want <= CNT_ZERO;
        end
        else
        begin
            if (state == ST_IDLE && wait_port.load)
                want <= wait_port.load_count;
            held <= (state == ST_WAIT) ? held + CNT_ONE : CNT_ZERO;
        end
    end

    release_len_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(wait_port.busy) |-> held == want)
        else $error("hold length differs from loaded length");

    load_start_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (state == ST_IDLE && wait_port.load) |=> wait_port.busy)
        else $error("load did not start the wait");

endmodule

// >>> logic/wake_wait_if.sv
// Interface: load request and status between wake control and the wait counter
`timescale 1ns/100ps
interface wake_wait_if #(parameter int CNT_W = 17);
    logic             load;        // One-cycle load pulse
    logic [CNT_W-1:0] load_count;  // Wait length in states
    logic             busy;        // Wait in progress

    modport ctrl (output load, output load_count, input busy);
    modport cnt  (input load, input load_count, output busy);
endinterface

// >>> sim/tb.sv
// Testbench: register access, wake wait lengths and watch exit clock choice
`timescale 1ns/100ps
module tb;
    import wake_pkg::*;

    // ----------------------------------------------------------------
    // Settings
    // ----------------------------------------------------------------
    // Short wait table per selector code, keeps the run brief
    localparam int unsigned WT [8] = '{16, 20, 9, 10, 11, 2, 5, 7};
    localparam int          TMO    = 3000;  // Whole run needs a few hundred cycles

    logic                 i_clk;
    logic                 i_resetn;
    logic                 i_wb_cyc;
    logic                 i_wb_stb;
    logic                 i_wb_we;
    logic [ADR_W-1:0]     i_wb_adr;
    logic [3:0]           i_wb_sel;
    logic [BUS_DW-1:0]    i_wb_dat;
    logic [BUS_DW-1:0]    o_wb_dat;
    logic                 o_wb_ack;
    logic                 i_wake_event;
    logic                 i_watch_exit;
    logic                 o_hold;
    logic                 o_cpu_clk_sub;
    logic [BUS_DW-1:0]    rd;
    int                   n;
    int                   miscompares;
    int                   n_checks;
    int                   cycles;

    standby_wake_wait_and_clock_select #(
        .CNT_W (CNT_W_DEF), .WAIT0 (WT[0]), .WAIT1 (WT[1]), .WAIT2 (WT[2]),
        .WAIT3 (WT[3]), .WAIT4 (WT[4]), .WAIT5 (WT[5]), .WAIT6 (WT[6]), .WAIT7 (WT[7])
    ) i_standby_wake_wait_and_clock_select (
        .i_clk         (i_clk),
        .i_resetn      (i_resetn),
        .i_wb_cyc      (i_wb_cyc),
        .i_wb_stb      (i_wb_stb),
        .i_wb_we       (i_wb_we),
        .i_wb_adr      (i_wb_adr),
        .i_wb_sel      (i_wb_sel),
        .i_wb_dat      (i_wb_dat),
        .o_wb_dat      (o_wb_dat),
        .o_wb_ack      (o_wb_ack),
        .i_wake_event  (i_wake_event),
        .i_watch_exit  (i_watch_exit),
        .o_hold        (o_hold),
        .o_cpu_clk_sub (o_cpu_clk_sub)
    );

    // ----------------------------------------------------------------
    // Clock and timeout
    // ----------------------------------------------------------------
    always #4 i_clk = ~i_clk;

    // A hang anywhere ends in the same closing report
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == TMO)
        begin
            miscompares++;
            $display("FAIL timeout expected below %0d got %0d", TMO, cycles);
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Compare tasks and closing report
    // ----------------------------------------------------------------
    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h got %h", name, exp, got);
        end
    endtask

    task automatic chk_cnt(input string name, input int exp, input int got);
        n_checks++;
        if (got != exp)
        begin
            miscompares++;
            $display("FAIL %s expected %0d got %0d", name, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Wishbone classic master, one idle cycle between transfers
    // ----------------------------------------------------------------
    task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [3:0] sel,
                           input logic [BUS_DW-1:0] wdat, output logic [BUS_DW-1:0] rdat);
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= we;
        i_wb_adr <= adr;
        i_wb_sel <= sel;
        i_wb_dat <= wdat;
        @(posedge i_clk);
        // Request stands until ack is seen at an edge; only the run timeout ends the wait
        while (o_wb_ack !== 1'b1)
        begin
            @(posedge i_clk);
        end
        rdat = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we  <= 1'b0;
    endtask

    // Field image of the control register
    function automatic logic [BUS_DW-1:0] ctrl_val(input logic [2:0] code, input logic clk,
                                                   input logic rsvd);
        logic [BUS_DW-1:0] v;
        v = RD_ZERO;
        v[WAIT_SEL_MSB:WAIT_SEL_LSB] = code;
        v[CLK_SEL_BIT] = clk;
        v[RSVD_BIT] = rsvd;
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Power-mode event drivers
    // ----------------------------------------------------------------
    // Pulse a wake and count held cycles; optional second wake mid-hold
    task automatic wake_run(input logic again, output int held);
        int k;
        @(posedge i_clk);
        i_wake_event <= 1'b1;
        @(posedge i_clk);
        i_wake_event <= 1'b0;
        held = 0;
        for (k = 0; k < 100; k++)
        begin
            @(posedge i_clk);
            if (o_hold !== 1'b1)
                break;
            held++;
            i_wake_event <= again && held == 3;
        end
    endtask

    task automatic watch_exit();
        @(posedge i_clk);
        i_watch_exit <= 1'b1;
        @(posedge i_clk);
        i_watch_exit <= 1'b0;
        @(posedge i_clk);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        i_resetn = 1'b0;
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wake_event, i_watch_exit} = 5'h00;
        i_wb_adr = 4'h0;
        i_wb_sel = 4'h0;
        i_wb_dat = 32'h0000_0000;
        miscompares = 0;
        n_checks = 0;
        cycles = 0;
        repeat (16) @(posedge i_clk);
        chk32("hold_in_reset", 32'h0, {31'h0, o_hold});
        chk32("clk_in_reset", 32'h0, {31'h0, o_cpu_clk_sub});
        i_resetn <= 1'b1;
        wb_xfer(1'b0, ADR_CTRL, 4'hF, 32'h0, rd);
        chk32("ctrl_reset", ctrl_val(WAIT_SEL_RST, CLK_SEL_RST, RSVD_VAL), rd);
        wb_xfer(1'b0, ADR_STATUS, 4'hF, 32'h0, rd);
        chk32("status_reset", 32'h0, rd);
        // Every selector code: read back, then measure the hold it gives
        for (int c = 0; c < 8; c++)
        begin
            // Software side picks each code in turn; code 5 is the external clock choice
            wb_xfer(1'b1, ADR_CTRL, 4'hF, ctrl_val(3'(c), c[0], 1'b0), rd);
            wb_xfer(1'b0, ADR_CTRL, 4'hF, 32'h0, rd);
            chk32("ctrl_rdback", ctrl_val(3'(c), c[0], RSVD_VAL), rd);
            wake_run(c == 0, n);
            chk_cnt("hold_len", int'(WT[c]), n);
        end
        // Byte lane 0 off: write must not land
        wb_xfer(1'b1, ADR_CTRL, 4'hE, ctrl_val(3'h3, 1'b0, 1'b0), rd);
        wb_xfer(1'b0, ADR_CTRL, 4'hF, 32'h0, rd);
        chk32("ctrl_sel_off", ctrl_val(3'h7, 1'b1, RSVD_VAL), rd);
        // Unmapped place reads zero and leaves control alone
        wb_xfer(1'b1, 4'h8, 4'hF, 32'hFFFF_FFFF, rd);
        wb_xfer(1'b0, 4'h8, 4'hF, 32'h0, rd);
        chk32("unmapped_rd", RD_ZERO, rd);
        wb_xfer(1'b0, ADR_CTRL, 4'hF, 32'h0, rd);
        chk32("ctrl_after_unmap", ctrl_val(3'h7, 1'b1, RSVD_VAL), rd);
        // Clock choice only moves at a watch exit
        chk32("clk_before_exit", {31'h0, CLK_MAIN}, {31'h0, o_cpu_clk_sub});
        watch_exit();
        chk32("clk_sub", {31'h0, CLK_SUB}, {31'h0, o_cpu_clk_sub});
        wb_xfer(1'b0, ADR_STATUS, 4'hF, 32'h0, rd);
        chk32("status_clk", 32'h1 << ST_CLK_BIT, rd);
        wb_xfer(1'b1, ADR_CTRL, 4'hF, ctrl_val(3'h0, CLK_MAIN, 1'b0), rd);
        chk32("clk_held", {31'h0, CLK_SUB}, {31'h0, o_cpu_clk_sub});
        watch_exit();
        chk32("clk_main", {31'h0, CLK_MAIN}, {31'h0, o_cpu_clk_sub});
        end_sim();
    end
endmodule
